// [hdl/pmi2c_slave.sv]
// Two-wire slave end running on the link clock, with a user register port.
`timescale 1ns/1ns
`include "pmi2c_map.svh"
module pmi2c_slave #(
  parameter int FILT_SLOW = `PMI2C_FILT_SLOW,
  parameter int FILT_FAST = `PMI2C_FILT_FAST
) (
  // Clock and reset
  input  wire logic                  lnk_clk,
  input  wire logic                  rst_n,
  // Bus
  pmi2c_bus_if.slave                 bus,
  // Options
  input  wire logic                  addr_opt,
  input  wire logic                  test_unlock,
  // Register port and fast-mode flag
  output logic                       reg_wr_r,
  output pmi2c_pkg::pmi2c_byte_t     reg_ptr_r,
  output pmi2c_pkg::pmi2c_byte_t     reg_wdata_r,
  input  wire pmi2c_pkg::pmi2c_byte_t reg_rdata,
  output logic                       hs_mode_r
);
  import pmi2c_pkg::*;
  typedef enum {PMI2C_S_IDLE, PMI2C_S_ADDR, PMI2C_S_PTR, PMI2C_S_WDAT,
                PMI2C_S_RDAT} pmi2c_st_e;
  // ---------------------------------------------------------------
  // Synchronisers and glitch filters
  // ---------------------------------------------------------------
  logic [1:0] scl_s_r, sda_s_r;
  logic [3:0] scl_cnt_r, sda_cnt_r;
  logic       scl_f_r, sda_f_r, scl_q_r, sda_q_r;
  wire  [3:0] flim = hs_mode_r ? 4'(FILT_FAST) : 4'(FILT_SLOW);
  always_ff @(posedge lnk_clk) begin
    scl_s_r <= {scl_s_r[0], bus.scl};
    sda_s_r <= {sda_s_r[0], bus.sda};
  end
  // A level must hold for flim+1 cycles before it is believed.
  always_ff @(posedge lnk_clk) begin
    if (!rst_n) begin
      scl_cnt_r <= 4'h0;
      sda_cnt_r <= 4'h0;
      scl_f_r   <= 1'b1;
      sda_f_r   <= 1'b1;
      scl_q_r   <= 1'b1;
      sda_q_r   <= 1'b1;
    end else begin
      scl_q_r <= scl_f_r;
      sda_q_r <= sda_f_r;
      if (scl_s_r[1] == scl_f_r) scl_cnt_r <= 4'h0;
      else if (scl_cnt_r >= flim) begin
        scl_f_r   <= scl_s_r[1];
        scl_cnt_r <= 4'h0;
      end else scl_cnt_r <= scl_cnt_r + 4'h1;
      if (sda_s_r[1] == sda_f_r) sda_cnt_r <= 4'h0;
      else if (sda_cnt_r >= flim) begin
        sda_f_r   <= sda_s_r[1];
        sda_cnt_r <= 4'h0;
      end else sda_cnt_r <= sda_cnt_r + 4'h1;
    end
  end
  // ---------------------------------------------------------------
  // Conditions and edges
  // ---------------------------------------------------------------
  wire start_det = scl_f_r & scl_q_r & sda_q_r & ~sda_f_r;
  wire stop_det  = scl_f_r & scl_q_r & ~sda_q_r & sda_f_r;
  wire scl_rise  = scl_f_r & ~scl_q_r;
  wire scl_fall  = ~scl_f_r & scl_q_r;
  function automatic logic addr_hit(input logic [6:0] a, input logic o,
                                    input logic t);
    addr_hit = (a == (o ? `PMI2C_ADDR_MAIN1 : `PMI2C_ADDR_MAIN0))
             | (t & (a == `PMI2C_ADDR_TEST));
  endfunction
  // ---------------------------------------------------------------
  // Byte engine
  // ---------------------------------------------------------------
  pmi2c_st_e  st_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic       ack_r, rd_r, mack_r;
  wire        byte_done = scl_rise & (bit_r == 4'd7);
  wire [7:0]  rx_byte   = {sh_r[6:0], sda_f_r};
  // Only an exact match answers; general call and the master code fall
  // through, so the identity read-back is never answered either.
  wire        hit = addr_hit(rx_byte[7:1], addr_opt, test_unlock)
                  & (rx_byte[7:1] != `PMI2C_ADDR_GCALL);
  wire        mcode = rx_byte[7:3] == `PMI2C_MCODE_TOP;
  always_ff @(posedge lnk_clk) begin
    if (!rst_n) begin
      st_r <= PMI2C_S_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ack_r <= 1'b0;
      rd_r <= 1'b0;
      mack_r <= 1'b0;
      hs_mode_r <= 1'b0;
      reg_wr_r <= 1'b0;
      reg_ptr_r <= 8'h00;
      reg_wdata_r <= 8'h00;
      bus.sda_s_o <= 1'b1;
      bus.sda_s_oe <= 1'b0;
    end else begin
      reg_wr_r <= 1'b0;
      if (stop_det) begin
        st_r <= PMI2C_S_IDLE;
        hs_mode_r <= 1'b0;
        bus.sda_s_oe <= 1'b0;
      end else if (start_det) begin
        st_r <= PMI2C_S_ADDR;
        bit_r <= 4'h0;
        bus.sda_s_oe <= 1'b0;
      end else if (st_r != PMI2C_S_IDLE) begin
        // While sending, the bit counter advances on falling edges only.
        if (scl_rise && bit_r < 4'd8 && st_r != PMI2C_S_RDAT) begin
          sh_r <= rx_byte;
          bit_r <= bit_r + 4'h1;
        end else if (scl_rise) begin
          mack_r <= ~sda_f_r;
        end
        if (byte_done) begin
          case (st_r)
            PMI2C_S_ADDR: begin
              ack_r <= hit;
              rd_r  <= rx_byte[0];
              if (mcode) hs_mode_r <= 1'b1;
            end
            PMI2C_S_PTR: begin
              ack_r <= 1'b1;
              reg_ptr_r <= rx_byte;
            end
            PMI2C_S_WDAT: begin
              ack_r <= 1'b1;
              reg_wdata_r <= rx_byte;
              reg_wr_r <= 1'b1;
            end
            default: ack_r <= 1'b0;
          endcase
        end
        if (scl_fall) begin
          if (bit_r == 4'd8 && st_r != PMI2C_S_RDAT) begin
            bus.sda_s_oe <= ack_r;
            bus.sda_s_o  <= 1'b0;
            bit_r <= 4'd9;
          end else if (bit_r == 4'd9 && st_r != PMI2C_S_RDAT) begin
            bus.sda_s_oe <= 1'b0;
            bit_r <= 4'h0;
            case (st_r)
              PMI2C_S_ADDR: st_r <= !ack_r ? PMI2C_S_IDLE :
                                    rd_r ? PMI2C_S_RDAT : PMI2C_S_PTR;
              PMI2C_S_PTR:  st_r <= PMI2C_S_WDAT;
              default:      st_r <= st_r;
            endcase
            if (ack_r && st_r == PMI2C_S_ADDR && rd_r) begin
              sh_r <= reg_rdata;
              bus.sda_s_oe <= ~reg_rdata[7];
              bus.sda_s_o  <= 1'b0;
              bit_r <= 4'h1;
            end else if (st_r == PMI2C_S_WDAT) begin
              reg_ptr_r <= reg_ptr_r + 8'h01;
            end
          end else if (st_r == PMI2C_S_RDAT) begin
            if (bit_r < 4'd8) begin
              bus.sda_s_oe <= ~sh_r[3'd7 - bit_r[2:0]];
              bit_r <= bit_r + 4'h1;
            end else if (bit_r == 4'd8) begin
              bus.sda_s_oe <= 1'b0;
              bit_r <= 4'd9;
            end else if (mack_r) begin
              sh_r <= reg_rdata;
              bus.sda_s_oe <= ~reg_rdata[7];
              bit_r <= 4'h1;
            end else begin
              st_r <= PMI2C_S_IDLE;
              bus.sda_s_oe <= 1'b0;
            end
          end
        end
        if (st_r == PMI2C_S_RDAT && bit_r == 4'd9 && scl_rise && ~sda_f_r)
          reg_ptr_r <= reg_ptr_r + 8'h01;
      end
    end
  end
  // The clock line is only ever sampled, never driven.
endmodule

// [hdl/pmi2c_map.svh]
// Constants for the two-wire slave interface and its bus master.
// Behaviour
// - Idle bus: both lines released high.
// - Start: data falls while clock high.
// - Stop: data rises while clock high.
// - Repeated start handled like start.
// - Master ends with not-acknowledge then stop.
// - Receiver acknowledges by holding data low.
// - Not-acknowledge: data released high.
// - Master watches acknowledges; a nack ends in stop, with no retry.
// - Every register pointer value is acknowledged.
// - Seven-bit address compared after start.
// - Test address 0x49 only when unlocked.
// - No other slave address is acknowledged.
// - Device never holds the clock line.
// - General call address is ignored.
// - No device identity read-back.
// - Rates up to 3.4MHz accepted.
// - Slow filters at power-up and stop.
// - Fast filters only after master code.
// - Eight bits, MSB first, then acknowledge.
// - Master code not acknowledged; holds until stop.
// - Write sets pointer; read returns from it.
`ifndef PMI2C_MAP_SVH
`define PMI2C_MAP_SVH
`define PMI2C_ADDR_MAIN1   7'h48
`define PMI2C_ADDR_MAIN0   7'h40
`define PMI2C_ADDR_TEST    7'h49
`define PMI2C_ADDR_GCALL   7'h00
`define PMI2C_MCODE_TOP    5'h01
`define PMI2C_FILT_SLOW    3
`define PMI2C_FILT_FAST    1
`define PMI2C_DIV_DEFAULT  5
`endif

// [hdl/pmi2c_pkg.sv]
// Types shared by the two ends.
package pmi2c_pkg;
  typedef enum logic [1:0] {PMI2C_OP_WRITE, PMI2C_OP_READ} pmi2c_op_e;
  typedef logic [7:0] pmi2c_byte_t;
endpackage

// [hdl/pmi2c_bus_if.sv]
// Open-drain two-wire bus joining the master and the slave.
`timescale 1ns/1ns
interface pmi2c_bus_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Wired-AND with pull-ups: a line is low only while someone drives low.
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe,
                  input scl, sda);
  modport slave (output sda_s_o, sda_s_oe, input scl, sda);
endinterface

// [hdl/pmi2c_master.sv]
// Two-wire bus master end: makes the bus clock by dividing its own.
`timescale 1ns/1ns
`include "pmi2c_map.svh"
module pmi2c_master #(
  parameter int DIV = `PMI2C_DIV_DEFAULT
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // Bus
  pmi2c_bus_if.master                 bus,
  // Command
  input  wire logic                   cmd_go,
  input  wire pmi2c_pkg::pmi2c_op_e   cmd_op,
  input  wire logic [6:0]             cmd_addr,
  input  wire pmi2c_pkg::pmi2c_byte_t cmd_ptr,
  input  wire pmi2c_pkg::pmi2c_byte_t cmd_wdata,
  output logic                        busy_r,
  output logic                        done_r,
  output logic                        nack_r,
  output pmi2c_pkg::pmi2c_byte_t      rdata_r
);
  import pmi2c_pkg::*;
  typedef enum {PMI2C_M_IDLE, PMI2C_M_START, PMI2C_M_BIT, PMI2C_M_STOP}
    pmi2c_mst_e;
  // Each bit takes four phases of DIV sys_clk cycles.
  pmi2c_mst_e st_r;
  logic [7:0] tick_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [1:0] byte_r;
  logic [7:0] sh_r;
  logic       sda_r, rs_r, rd_r;
  wire        tick = tick_r == 8'(DIV - 1);
  logic [1:0] sda_sy_r;
  always_ff @(posedge sys_clk) sda_sy_r <= {sda_sy_r[0], bus.sda};
  wire [7:0]  next_byte = (byte_r == 2'd0) ? {cmd_addr, 1'b0} :
                          (byte_r == 2'd1) ? cmd_ptr :
                          rd_r ? {cmd_addr, 1'b1} : cmd_wdata;
  always_comb begin
    bus.sda_m_o = 1'b0;
    bus.sda_m_oe = ~sda_r;
    bus.scl_o = 1'b0;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= PMI2C_M_IDLE;
      tick_r <= 8'h00;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      sh_r <= 8'h00;
      sda_r <= 1'b1;
      rs_r <= 1'b0;
      rd_r <= 1'b0;
      bus.scl_oe <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      nack_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      done_r <= 1'b0;
      tick_r <= tick ? 8'h00 : tick_r + 8'h01;
      if (tick) ph_r <= ph_r + 2'h1;
      case (st_r)
        PMI2C_M_IDLE: begin
          ph_r <= 2'h0;
          if (cmd_go) begin
            st_r <= PMI2C_M_START;
            busy_r <= 1'b1;
            nack_r <= 1'b0;
            byte_r <= 2'h0;
            rd_r <= cmd_op == PMI2C_OP_READ;
            rs_r <= 1'b0;
          end
        end
        PMI2C_M_START: if (tick) begin
          case (ph_r)
            2'd0: begin sda_r <= 1'b1; bus.scl_oe <= 1'b0; end
            2'd1: sda_r <= 1'b0;
            2'd2: bus.scl_oe <= 1'b1;
            default: begin
              st_r <= PMI2C_M_BIT;
              sh_r <= rs_r ? {cmd_addr, 1'b1} : next_byte;
              bit_r <= 4'h0;
              ph_r <= 2'h0;
            end
          endcase
        end
        PMI2C_M_BIT: if (tick) begin
          case (ph_r)
            2'd0: sda_r <= (bit_r < 4'd8) ? sh_r[7] : 1'b1;
            2'd1: bus.scl_oe <= 1'b0;
            2'd2: begin
              if (bit_r < 4'd8) sh_r <= {sh_r[6:0], sda_sy_r[1]};
              else if (sda_sy_r[1] && byte_r != 2'd3)
                nack_r <= 1'b1;
            end
            default: begin
              bus.scl_oe <= 1'b1;
              bit_r <= bit_r + 4'h1;
              if (bit_r == 4'd8) begin
                if (byte_r == 2'd3) rdata_r <= sh_r;
                if (nack_r || byte_r == 2'd3 ||
                    (!rd_r && byte_r == 2'd2)) begin
                  st_r <= PMI2C_M_STOP;
                  sda_r <= 1'b0;
                end else if (rd_r && byte_r == 2'd1) begin
                  st_r <= PMI2C_M_START;
                  rs_r <= 1'b1;
                  byte_r <= 2'd2;
                end else if (rs_r) begin
                  // The read address was acknowledged; now take the data.
                  byte_r <= 2'd3;
                  sh_r <= 8'hff;
                  bit_r <= 4'h0;
                end else begin
                  byte_r <= byte_r + 2'h1;
                  bit_r <= 4'h0;
                  sh_r <= (byte_r == 2'd0) ? cmd_ptr : cmd_wdata;
                end
              end
            end
          endcase
          // During read data the master releases data; it then nacks.
          if (ph_r == 2'd0 && byte_r == 2'd3) sda_r <= 1'b1;
        end
        PMI2C_M_STOP: if (tick) begin
          case (ph_r)
            2'd0: sda_r <= 1'b0;
            2'd1: bus.scl_oe <= 1'b0;
            2'd2: sda_r <= 1'b1;
            default: begin
              st_r <= PMI2C_M_IDLE;
              busy_r <= 1'b0;
              done_r <= 1'b1;
            end
          endcase
        end
        default: st_r <= PMI2C_M_IDLE;
      endcase
    end
  end
endmodule

// [tb/pmi2c_assertions.sv]
// Checker for the two-wire bus between the master and the slave.
`timescale 1ns/1ns
module pmi2c_assertions (
  // Clock and reset
  input wire logic lnk_clk,
  input wire logic rst_n,
  // Bus
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  // Slave options and mode
  input wire logic addr_opt,
  input wire logic test_unlock,
  input wire logic hs_mode_r
);
  logic       scl_q, sda_q, lo_q, frm_r, fst_r, sec_r, qt_r, hc_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  wire        lo = sda_s_oe & ~sda_s_o;
  wire        st = sda_q & ~sda & scl & scl_q;
  wire        sp = ~sda_q & sda & scl & scl_q;
  wire        rs = ~scl_q & scl;
  wire        nth = rs & (bit_r == 4'h8);
  wire        hit = sh_r[7:1] == (addr_opt ? 7'h48 : 7'h40) ||
                    test_unlock && sh_r[7:1] == 7'h49;
  // ------------
  // Bus tracking
  // ------------
  // Raw lines are watched, so every bound allows for the slave's input delay.
  always_ff @(posedge lnk_clk) {scl_q, sda_q, lo_q} <= {scl, sda, lo};
  always_ff @(posedge lnk_clk) begin
    if (!rst_n || sp) begin
      {frm_r, fst_r, sec_r, qt_r, hc_r} <= 5'h00;
      bit_r <= 4'h0;
    end else if (st) begin
      {frm_r, fst_r, sec_r, qt_r} <= 4'hc;
      bit_r <= 4'h0;
    end else if (rs) begin
      bit_r <= (bit_r == 4'h9) ? 4'h1 : bit_r + 4'h1;
      sh_r <= {sh_r[6:0], sda};
      hc_r <= hc_r | (fst_r & (bit_r == 4'h7) & (sh_r[6:2] == 5'h01));
      if (nth) begin
        fst_r <= 1'b0;
        sec_r <= fst_r & hit & ~sh_r[0];
        qt_r <= qt_r | (fst_r & ~hit);
      end
    end
  end
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge lnk_clk); endclocking
  default disable iff (!rst_n);
  sequence s_adr; nth && fst_r; endsequence
  sequence s_ptr; nth && sec_r; endsequence
  property p_ack; s_adr |-> sda == !hit; endproperty
  property p_ptr; s_ptr |-> !sda; endproperty
  property p_rel; !frm_r |-> !lo; endproperty
  property p_scl; !frm_r |-> scl; endproperty
  property p_stb; scl && scl_q |-> lo == lo_q; endproperty
  property p_hsc; sp |-> ##[1:12] !hs_mode_r; endproperty
  property p_hsr; $rose(hs_mode_r) |-> hc_r; endproperty
  property p_qt; qt_r |-> !lo; endproperty
  a_ack: assert property (p_ack)
    else $error("address acknowledge wrong");
  a_ptr: assert property (p_ptr)
    else $error("pointer not acknowledged");
  a_rel: assert property (p_rel)
    else $error("slave holds data while idle");
  a_scl: assert property (p_scl)
    else $error("clock low while idle");
  a_stb: assert property (p_stb)
    else $error("slave data moved while clock high");
  a_hsc: assert property (p_hsc)
    else $error("fast mode kept after stop");
  a_hsr: assert property (p_hsr)
    else $error("fast mode without master code");
  a_qt: assert property (p_qt)
    else $error("slave drives after refusing address");
endmodule

// [tb/tb.sv]
// Bench joining the master and the slave across the bus interface.
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb;
  import pmi2c_pkg::*;
  logic        sys_clk = 1'b0;
  logic        lnk_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_go = 1'b0;
  pmi2c_op_e   cmd_op = PMI2C_OP_WRITE;
  logic [6:0]  cmd_addr = 7'h00;
  pmi2c_byte_t cmd_ptr = 8'h00;
  pmi2c_byte_t cmd_wdata = 8'h00;
  logic        addr_opt = 1'b1;
  logic        test_unlock = 1'b0;
  logic        hs_seen = 1'b0;
  logic        busy_r, done_r, nack_r, hs_mode_r, reg_wr_r;
  pmi2c_byte_t rdata_r, reg_ptr_r, reg_wdata_r, reg_rdata;
  logic [31:0] seed = 32'hbcc9;
  logic [9:0]  exp_q[$];
  logic [9:0]  e;
  logic [15:0] wr_q[$];
  logic [6:0]  tbl[5];
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;
  always #50 sys_clk = ~sys_clk;
  always #7.5 lnk_clk = ~lnk_clk;
  // Read data follows the pointer, so the expected byte needs no register map.
  assign reg_rdata = reg_ptr_r ^ 8'h5a;
  pmi2c_bus_if bus_if ();
  pmi2c_master pmi2c_master_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_if), .cmd_go(cmd_go),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_ptr(cmd_ptr),
    .cmd_wdata(cmd_wdata), .busy_r(busy_r), .done_r(done_r),
    .nack_r(nack_r), .rdata_r(rdata_r));
  pmi2c_slave pmi2c_slave_inst (
    .lnk_clk(lnk_clk), .rst_n(rst_n), .bus(bus_if), .addr_opt(addr_opt),
    .test_unlock(test_unlock), .reg_wr_r(reg_wr_r), .reg_ptr_r(reg_ptr_r),
    .reg_wdata_r(reg_wdata_r), .reg_rdata(reg_rdata),
    .hs_mode_r(hs_mode_r));
  pmi2c_assertions chk_inst (
    .lnk_clk(lnk_clk), .rst_n(rst_n), .scl(bus_if.scl), .sda(bus_if.sda),
    .sda_s_o(bus_if.sda_s_o), .sda_s_oe(bus_if.sda_s_oe),
    .addr_opt(addr_opt), .test_unlock(test_unlock), .hs_mode_r(hs_mode_r));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic wrap_up();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // -------------------
  // Driver and monitors
  // -------------------
  task automatic run(input pmi2c_op_e op, input logic [6:0] a,
                     input logic o, input logic u);
    logic m;
    int   n;
    @(posedge sys_clk);
    #1;
    seed = xs(seed);
    m = a == (o ? 7'h48 : 7'h40) || u && a == 7'h49;
    addr_opt = o;
    test_unlock = u;
    cmd_op = op;
    cmd_addr = a;
    cmd_ptr = seed[7:0];
    cmd_wdata = seed[15:8];
    cmd_go = 1'b1;
    exp_q.push_back({op == PMI2C_OP_READ && m, !m, seed[7:0] ^ 8'h5a});
    if (m && op == PMI2C_OP_WRITE) wr_q.push_back({seed[7:0], seed[15:8]});
    @(posedge sys_clk);
    #1 cmd_go = 1'b0;
    for (n = 0; n < 5000 && done_r !== 1'b1; n++) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      wrap_up();
    end
    if (done_r === 1'b1) begin
      e = exp_q.pop_front();
      `CHK(nack_r, e[8])
      if (e[9]) `CHK(rdata_r, e[7:0])
    end
  end
  always @(posedge lnk_clk) begin
    if (hs_mode_r === 1'b1) hs_seen = 1'b1;
    if (reg_wr_r === 1'b1) begin
      if (wr_q.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK({reg_ptr_r, reg_wdata_r}, wr_q.pop_front())
    end
  end
  initial begin
    tbl = '{7'h48, 7'h40, 7'h49, 7'h00, 7'h00};
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    // Every option pair meets main, other main, test, general call, random.
    for (int o = 1; o >= 0; o--)
      for (int u = 0; u < 2; u++)
        for (int i = 0; i < 10; i++) begin
          // Keep the random address clear of the master codes.
          tbl[4] = seed[22:16] | 7'h10;
          run(i[0] ? PMI2C_OP_READ : PMI2C_OP_WRITE, tbl[i / 2], o[0], u[0]);
        end
    `CHK(hs_seen, 1'b0)
    for (int a = 4; a < 8; a++) begin
      run(PMI2C_OP_WRITE, a[6:0], 1'b1, 1'b0);
      repeat (2) @(posedge sys_clk);
      `CHK(hs_seen, 1'b1)
      `CHK(hs_mode_r, 1'b0)
      hs_seen = 1'b0;
    end
    wrap_up();
  end
endmodule
